/* design/scrd_consts.svh */
/*
 * Constants for the shadow, cacheability and decode option register bank.
 * Assumes it is included by bare name from the design files of both ends.
 */
`ifndef SCRD_CONSTS_SVH
`define SCRD_CONSTS_SVH

`define SCRD_IDX_DSHADOW 8'h37
`define SCRD_IDX_CSHE 8'h38
`define SCRD_IDX_CDCACHE 8'h39
`define SCRD_IDX_DECODE 8'h3a

`define SCRD_RST_DSHADOW 8'hff
`define SCRD_RST_CSHE 8'hf0
`define SCRD_RST_CDCACHE 8'h00
`define SCRD_RST_DECODE 8'h00

`define SCRD_DEC_KBD_OFF 7
`define SCRD_DEC_KRST_OFF 6
`define SCRD_DEC_MW_OFF 5
`define SCRD_DEC_FAST 4
`define SCRD_DEC_ROM512 3
`define SCRD_DEC_IO16 2
`define SCRD_DEC_MODULE 1
`define SCRD_DEC_BRIDGE 0

`define SCRD_IGN_C 0
`define SCRD_IGN_D 1
`define SCRD_IGN_E 2

`define SCRD_SEG_C 4'hc
`define SCRD_SEG_D 4'hd
`define SCRD_SEG_E 4'he
`define SCRD_ROM64_TAG 11'h7ff
`define SCRD_ROM512_TAG 8'hff
`define SCRD_KBD_DATA_PORT 16'h0060
`define SCRD_KBD_CMD_PORT 16'h0064
`define SCRD_KBD_RESET_CMD 8'hfe

`endif

/* design/scrd_device.sv */
/*
 * Register bank end: holds indices 37h-3Ah and decodes each bus cycle into
 * shadow, L1 cacheability, ROM and keyboard selects and keyboard reset.
 * Assumes the enables of indices 23h, 26h and 2Eh come from elsewhere in
 * the chip on ref_clk, and that the DRAM space select arrives from a pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scrd_consts.svh"
module scrd_device
   import scrd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   scrd_link_if.dev link,
   input wire logic [7:0] dShadowEnable23,
   input wire logic [3:0] cShadowEnable26,
   input wire logic [2:0] cacheIgnore2e,
   input wire logic dram_space_sel_n,
   output logic shadowHit,
   output logic l1Cacheable,
   output logic bios_rom_select_n,
   output logic keyboard_ctrl_select_n,
   output logic keyboardReset,
   output logic mem_word_cycle_ind_n,
   output logic fastA2A3Switch,
   output logic ioDecode16,
   output logic cacheModuleEnable,
   output logic bridgeSupportEnable
);

   scrd_dev_state_t cur;
   scrd_dev_state_t next_cur;

   // ************************************************************
   // Decode helpers
   // ************************************************************

   // True when the I/O port address matches, honouring the decode width.
   function automatic logic ioMatch(input logic [31:0] addr, input logic [15:0] port,
                                    input logic wide);
      if (wide) begin
         ioMatch = (addr[15:0] == port);
      end else begin
         ioMatch = (addr[9:0] == port[9:0]);
      end
   endfunction : ioMatch

   // Picks one bit of a four-bit group of 16KB blocks for a segment.
   function automatic logic cacheBit(input logic [3:0] bits, input logic [1:0] blk,
                                     input logic ignore);
      cacheBit = bits[blk] & ~ignore;
   endfunction : cacheBit

   // ************************************************************
   // Next state
   // ************************************************************

   always_comb begin
      logic [3:0] seg;
      logic [2:0] blk8k;
      logic [1:0] blk16k;
      logic [1:0] cUpperBlk;
      logic lowMeg;
      logic memCyc;
      logic ioCyc;
      logic wideIo;
      logic cmdPort;
      logic kbdPort;
      seg = link.cycAddr[19:16];
      blk8k = link.cycAddr[15:13];
      blk16k = link.cycAddr[15:14];
      cUpperBlk = link.cycAddr[14:13];
      lowMeg = (link.cycAddr[31:20] == 12'h000);
      memCyc = link.cycValid & ~link.cycIo;
      ioCyc = link.cycValid & link.cycIo;
      // In 10-bit mode the upper address bits are ignored, so every 1KB
      // alias of the keyboard ports decodes as well.
      wideIo = cur.decodeCtl[`SCRD_DEC_IO16];
      cmdPort = ioMatch(link.cycAddr, `SCRD_KBD_CMD_PORT, wideIo);
      kbdPort = ioMatch(link.cycAddr, `SCRD_KBD_DATA_PORT, wideIo) | cmdPort;
      next_cur = cur;
      next_cur.dramSync1 = dram_space_sel_n;
      next_cur.dramSync2 = cur.dramSync1;

      // ************************************************************
      // Register access
      // ************************************************************

      // Writes land at the edge that ends the access, so any cycle offered
      // from the next edge on is decoded with the new value.
      next_cur.cfgAck = link.cfgWr | link.cfgRd;
      next_cur.cfgRdData = 8'h00;
      if (link.cfgWr) begin
         case (link.cfgIndex)
            `SCRD_IDX_DSHADOW: next_cur.dShadow = link.cfgWrData;
            `SCRD_IDX_CSHE: next_cur.cShadowECache = link.cfgWrData;
            `SCRD_IDX_CDCACHE: next_cur.cdCache = link.cfgWrData;
            `SCRD_IDX_DECODE: next_cur.decodeCtl = link.cfgWrData;
            default: next_cur.dShadow = cur.dShadow;
         endcase
      end
      if (link.cfgRd) begin
         case (link.cfgIndex)
            `SCRD_IDX_DSHADOW: next_cur.cfgRdData = cur.dShadow;
            `SCRD_IDX_CSHE: next_cur.cfgRdData = cur.cShadowECache;
            `SCRD_IDX_CDCACHE: next_cur.cfgRdData = cur.cdCache;
            `SCRD_IDX_DECODE: next_cur.cfgRdData = cur.decodeCtl;
            default: next_cur.cfgRdData = 8'h00;
         endcase
      end

      // ************************************************************
      // Bus cycle decode
      // ************************************************************

      // Cycle results stand for one cycle after each offered cycle.
      next_cur.shadowHit = 1'b0;
      next_cur.l1Cacheable = 1'b0;
      next_cur.romSelN = 1'b1;
      next_cur.kbdSelN = 1'b1;
      next_cur.kbdReset = 1'b0;
      next_cur.memWordN = 1'b1;

      if (memCyc && lowMeg) begin
         if (seg == `SCRD_SEG_D) begin
            next_cur.shadowHit = cur.dShadow[blk8k]
                               & dShadowEnable23[blk8k];
            next_cur.l1Cacheable = cacheBit(cur.cdCache[7:4], blk16k,
                                            cacheIgnore2e[`SCRD_IGN_D]);
         end else if (seg == `SCRD_SEG_C) begin
            // Only the upper half of the C segment has shadow control here.
            if (link.cycAddr[15]) begin
               next_cur.shadowHit = cur.cShadowECache[{1'b1, cUpperBlk}]
                                  & cShadowEnable26[cUpperBlk];
            end
            next_cur.l1Cacheable = cacheBit(cur.cdCache[3:0], blk16k,
                                            cacheIgnore2e[`SCRD_IGN_C]);
         end else if (seg == `SCRD_SEG_E) begin
            next_cur.l1Cacheable = cacheBit(cur.cShadowECache[3:0], blk16k,
                                            cacheIgnore2e[`SCRD_IGN_E]);
         end
      end

      // The DRAM select pin reaches this decode two clocks late through its
      // synchroniser, so it must settle before the cycle is offered.
      // High BIOS spaces ignore address bits 31-27, so every alias decodes.
      if (memCyc && cur.dramSync2) begin
         if (link.cycAddr[26:16] == `SCRD_ROM64_TAG) begin
            next_cur.romSelN = 1'b0;
         end else if (cur.decodeCtl[`SCRD_DEC_ROM512]
                      && link.cycAddr[26:19] == `SCRD_ROM512_TAG) begin
            next_cur.romSelN = 1'b0;
         end
      end

      if (ioCyc && kbdPort && !cur.decodeCtl[`SCRD_DEC_KBD_OFF]) begin
         next_cur.kbdSelN = 1'b0;
      end
      if (ioCyc && link.cycWrite && !cur.decodeCtl[`SCRD_DEC_KRST_OFF] && cmdPort
          && link.cycData == `SCRD_KBD_RESET_CMD) begin
         next_cur.kbdReset = 1'b1;
      end
      if (memCyc && link.cycDma && !cur.decodeCtl[`SCRD_DEC_MW_OFF]) begin
         next_cur.memWordN = 1'b0;
      end
   end

   // ************************************************************
   // State register
   // ************************************************************

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cur <= '0;
         // D_segment_shadow_enable leaves reset with every D block on; index 23h still gates them.
         cur.dShadow <= `SCRD_RST_DSHADOW;
         cur.cShadowECache <= `SCRD_RST_CSHE;
         cur.cdCache <= `SCRD_RST_CDCACHE;
         cur.decodeCtl <= `SCRD_RST_DECODE;
         cur.dramSync1 <= 1'b1;
         cur.dramSync2 <= 1'b1;
         cur.romSelN <= 1'b1;
         cur.kbdSelN <= 1'b1;
         cur.memWordN <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   assign link.cfgAck = cur.cfgAck;
   assign link.cfgRdData = cur.cfgRdData;
   assign shadowHit = cur.shadowHit;
   assign l1Cacheable = cur.l1Cacheable;
   assign bios_rom_select_n = cur.romSelN;
   assign keyboard_ctrl_select_n = cur.kbdSelN;
   assign keyboardReset = cur.kbdReset;
   assign mem_word_cycle_ind_n = cur.memWordN;
   assign fastA2A3Switch = cur.decodeCtl[`SCRD_DEC_FAST];
   assign ioDecode16 = cur.decodeCtl[`SCRD_DEC_IO16];
   assign cacheModuleEnable = cur.decodeCtl[`SCRD_DEC_MODULE];
   assign bridgeSupportEnable = cur.decodeCtl[`SCRD_DEC_BRIDGE];

endmodule : scrd_device
`default_nettype wire

/* design/scrd_host.sv */
/*
 * Host processor end: turns user configuration requests into one-cycle
 * index accesses and forwards bus cycles to the register bank.
 * Assumes the user holds a request only while busy is low.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scrd_consts.svh"
module scrd_host
   import scrd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   scrd_link_if.host link,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [7:0] reqIndex,
   input wire logic [7:0] reqData,
   output logic busy,
   output logic rdDone,
   output logic [7:0] rdData,
   input wire logic busCycValid,
   input wire logic busCycIo,
   input wire logic busCycWrite,
   input wire logic busCycDma,
   input wire logic [31:0] busCycAddr,
   input wire logic [7:0] busCycData
);

   scrd_host_state_t_s_t cur;
   scrd_host_state_t_s_t next_cur;

   // ************************************************************
   // Next state
   // ************************************************************

   always_comb begin
      next_cur = cur;
      next_cur.cfgWr = 1'b0;
      next_cur.cfgRd = 1'b0;
      next_cur.rdDone = 1'b0;
      // Bus cycles are offered one cycle after the user presents them; a
      // cycle presented after a write's done pulse sees the new value.
      next_cur.cycValid = busCycValid;
      next_cur.cycIo = busCycIo;
      next_cur.cycWrite = busCycWrite;
      next_cur.cycDma = busCycDma;
      next_cur.cycAddr = busCycAddr;
      next_cur.cycData = busCycData;
      case (cur.state)
         SCRD_IDLE: begin
            if (reqValid) begin
               next_cur.cfgWr = reqWrite;
               next_cur.cfgRd = ~reqWrite;
               next_cur.cfgIndex = reqIndex;
               next_cur.cfgWrData = reqData;
               next_cur.busy = 1'b1;
               next_cur.state = SCRD_WAIT;
            end
         end
         SCRD_WAIT: begin
            if (link.cfgAck) begin
               next_cur.rdData = link.cfgRdData;
               next_cur.rdDone = 1'b1;
               next_cur.busy = 1'b0;
               next_cur.state = SCRD_IDLE;
            end
         end
         default: begin
            next_cur.state = SCRD_IDLE;
            next_cur.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cur <= '0;
         cur.state <= SCRD_IDLE;
      end else begin
         cur <= next_cur;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   assign link.cfgWr = cur.cfgWr;
   assign link.cfgRd = cur.cfgRd;
   assign link.cfgIndex = cur.cfgIndex;
   assign link.cfgWrData = cur.cfgWrData;
   assign link.cycValid = cur.cycValid;
   assign link.cycIo = cur.cycIo;
   assign link.cycWrite = cur.cycWrite;
   assign link.cycDma = cur.cycDma;
   assign link.cycAddr = cur.cycAddr;
   assign link.cycData = cur.cycData;
   assign busy = cur.busy;
   assign rdDone = cur.rdDone;
   assign rdData = cur.rdData;

endmodule : scrd_host
`default_nettype wire

/* design/scrd_link_if.sv */
/*
 * Carrier between the host processor side and the register bank.
 * Assumes both ends run on the same ref_clk and sys_rst.
 */
`timescale 1ns/1ps
`default_nettype none
interface scrd_link_if;
   logic cfgWr;
   logic cfgRd;
   logic [7:0] cfgIndex;
   logic [7:0] cfgWrData;
   logic cfgAck;
   logic [7:0] cfgRdData;
   logic cycValid;
   logic cycIo;
   logic cycWrite;
   logic cycDma;
   logic [31:0] cycAddr;
   logic [7:0] cycData;

   modport dev (
      input cfgWr, cfgRd, cfgIndex, cfgWrData, cycValid, cycIo, cycWrite, cycDma,
      input cycAddr, cycData,
      output cfgAck, cfgRdData
   );
   modport host (
      output cfgWr, cfgRd, cfgIndex, cfgWrData, cycValid, cycIo, cycWrite, cycDma,
      output cycAddr, cycData,
      input cfgAck, cfgRdData
   );
endinterface : scrd_link_if
`default_nettype wire

/* design/scrd_pkg.sv */
/*
 * Types shared by both ends of the shadow/cache/decode register bank.
 * Assumes the constants header is available on the include path.
 */
`default_nettype none
package scrd_pkg;

   typedef enum {SCRD_IDLE, SCRD_WAIT} scrd_host_state_t;

   typedef struct packed {
      logic [7:0] dShadow;
      logic [7:0] cShadowECache;
      logic [7:0] cdCache;
      logic [7:0] decodeCtl;
      logic cfgAck;
      logic [7:0] cfgRdData;
      logic dramSync1;
      logic dramSync2;
      logic shadowHit;
      logic l1Cacheable;
      logic romSelN;
      logic kbdSelN;
      logic kbdReset;
      logic memWordN;
   } scrd_dev_state_t;

   typedef struct packed {
      scrd_host_state_t state;
      logic cfgWr;
      logic cfgRd;
      logic [7:0] cfgIndex;
      logic [7:0] cfgWrData;
      logic busy;
      logic rdDone;
      logic [7:0] rdData;
      logic cycValid;
      logic cycIo;
      logic cycWrite;
      logic cycDma;
      logic [31:0] cycAddr;
      logic [7:0] cycData;
   } scrd_host_state_t_s_t;

endpackage : scrd_pkg
`default_nettype wire

/* tb/scrd_props.sv */
/*
 * Checker on the link between host end and register bank.
 * Assumes it is instantiated beside the link, sharing ref_clk and sys_rst.
 */
`timescale 1ns/1ps
`default_nettype none
module scrd_props (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic cfgWr,
   input wire logic cfgRd,
   input wire logic [7:0] cfgIndex,
   input wire logic [7:0] cfgWrData,
   input wire logic cfgAck,
   input wire logic [7:0] cfgRdData
);
   logic [7:0] m37, m38, m39, m3a;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // ********************************
   // Mirror of the four indices
   // ********************************
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         m37 <= 8'hff;
         m38 <= 8'hf0;
         m39 <= 8'h00;
         m3a <= 8'h00;
      end else if (cfgWr) begin
         case (cfgIndex)
            8'h37: m37 <= cfgWrData;
            8'h38: m38 <= cfgWrData;
            8'h39: m39 <= cfgWrData;
            8'h3a: m3a <= cfgWrData;
            default: ;
         endcase
      end
   end
   sequence sReq;
      cfgWr || cfgRd;
   endsequence
   sequence sAckPulse;
      cfgAck ##1 !cfgAck;
   endsequence
   property pRead(logic [7:0] idx, logic [7:0] exp);
      cfgRd && cfgIndex == idx |=> cfgRdData == exp;
   endproperty
   chk_ack_follows_req: assert property (sReq |=> sAckPulse)
      else $error("link acknowledge missing or too long");
   chk_ack_has_req: assert property (cfgAck |-> $past(cfgWr || cfgRd))
      else $error("link acknowledge without request");
   chk_data_idle_zero: assert property (!cfgAck |-> cfgRdData == 8'h00)
      else $error("read data not zero outside acknowledge");
   chk_read_dshadow: assert property (pRead(8'h37, m37))
      else $error("d_segment_shadow_enable read back wrong");
   chk_read_cshadow: assert property (pRead(8'h38, m38))
      else $error("c_shadow_e_cacheable read back wrong");
   chk_read_cdcache: assert property (pRead(8'h39, m39))
      else $error("cd_segment_cacheable read back wrong");
   chk_read_decode: assert property (pRead(8'h3a, m3a))
      else $error("decode_option_control read back wrong");
   chk_read_unmapped: assert property (cfgRd && (cfgIndex < 8'h37 || cfgIndex > 8'h3a)
      |=> cfgRdData == 8'h00) else $error("unmapped index read not zero");
endmodule : scrd_props
`default_nettype wire

/* tb/shadow_cache_region_decode_tb.sv */
/*
 * Self-checking bench: host end and register bank joined by the link.
 * Assumes the design files and constants header are on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
module shadow_cache_region_decode_tb;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reqValid = 1'b0;
   logic reqWrite = 1'b0;
   logic [7:0] reqIndex = 8'h00, reqData = 8'h00, busCycData = 8'h00, en23 = 8'hff;
   logic busCycValid = 1'b0, busCycIo = 1'b0, busCycWrite = 1'b0, busCycDma = 1'b0;
   logic [31:0] busCycAddr = 32'h00000000;
   logic [3:0] en26 = 4'hf;
   logic [2:0] ign = 3'h0;
   logic dramN = 1'b1;
   logic busy, rdDone, hit, l1, romN, kbdN, kbdRst, mwN, fast, io16, modEn, brEn;
   logic [7:0] rdData;
   int err_total = 0, check_count = 0, cycles = 0;
   scrd_link_if link();
   scrd_host i_scrd_host(.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
      .reqValid(reqValid), .reqWrite(reqWrite), .reqIndex(reqIndex), .reqData(reqData),
      .busy(busy), .rdDone(rdDone), .rdData(rdData), .busCycValid(busCycValid),
      .busCycIo(busCycIo), .busCycWrite(busCycWrite), .busCycDma(busCycDma),
      .busCycAddr(busCycAddr), .busCycData(busCycData));
   scrd_device i_scrd_device(.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
      .dShadowEnable23(en23), .cShadowEnable26(en26), .cacheIgnore2e(ign),
      .dram_space_sel_n(dramN), .shadowHit(hit), .l1Cacheable(l1), .bios_rom_select_n(romN),
      .keyboard_ctrl_select_n(kbdN), .keyboardReset(kbdRst), .mem_word_cycle_ind_n(mwN),
      .fastA2A3Switch(fast), .ioDecode16(io16), .cacheModuleEnable(modEn),
      .bridgeSupportEnable(brEn));
   scrd_props i_scrd_props(.ref_clk(ref_clk), .sys_rst(sys_rst), .cfgWr(link.cfgWr),
      .cfgRd(link.cfgRd), .cfgIndex(link.cfgIndex), .cfgWrData(link.cfgWrData),
      .cfgAck(link.cfgAck), .cfgRdData(link.cfgRdData));
   always #2.5 ref_clk = ~ref_clk;
   // ********************************
   // Tasks
   // ********************************
   task automatic end_of_test;
      $display("Checks %0d, errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // For a read, d is the value expected back.
   task automatic cfg(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int n;
      @(posedge ref_clk);
      reqValid <= 1'b1;
      reqWrite <= wr;
      reqIndex <= idx;
      reqData <= d;
      @(posedge ref_clk);
      reqValid <= 1'b0;
      @(posedge ref_clk);
      check("busy", {7'h00, busy}, 8'h01);
      n = 0;
      while (rdDone !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      check("done", {7'h00, rdDone}, 8'h01);
      check("latency", 8'(n), 8'h02);
      if (!wr) check("rdData", rdData, d);
   endtask : cfg
   // Kind is {io, write, dma}; exp is {hit, l1, rom_n, kbd_n, kbd_reset, mem_word_n}.
   task automatic bus(input logic [2:0] kind, input logic [31:0] a, input logic [7:0] d,
                      input logic [5:0] exp);
      @(posedge ref_clk);
      {busCycIo, busCycWrite, busCycDma} <= kind;
      busCycValid <= 1'b1;
      busCycAddr <= a;
      busCycData <= d;
      @(posedge ref_clk);
      busCycValid <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check("decode", {2'b00, hit, l1, romN, kbdN, kbdRst, mwN}, {2'b00, exp});
   endtask : bus
   // The run needs about two hundred cycles; the ceiling leaves wide margin.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         end_of_test();
      end
   end
   // ********************************
   // Main sequence
   // ********************************
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      cfg(0, 8'h37, 8'hff);
      cfg(0, 8'h38, 8'hf0);
      cfg(0, 8'h39, 8'h00);
      cfg(0, 8'h3a, 8'h00);
      cfg(1, 8'h3b, 8'h5a);
      cfg(0, 8'h3b, 8'h00);
      bus(3'b000, 32'h000d2000, 8'h00, 6'b101101);
      en23 <= 8'hfd;
      bus(3'b000, 32'h000d2000, 8'h00, 6'b001101);
      bus(3'b000, 32'h000c8000, 8'h00, 6'b101101);
      en26 <= 4'he;
      bus(3'b000, 32'h000c8000, 8'h00, 6'b001101);
      bus(3'b000, 32'h000ce000, 8'h00, 6'b101101);
      cfg(1, 8'h39, 8'h12);
      cfg(0, 8'h39, 8'h12);
      bus(3'b000, 32'h000d0000, 8'h00, 6'b111101);
      bus(3'b000, 32'h000c4000, 8'h00, 6'b011101);
      bus(3'b000, 32'h000d4000, 8'h00, 6'b101101);
      ign <= 3'b011;
      bus(3'b000, 32'h000d0000, 8'h00, 6'b101101);
      bus(3'b000, 32'h000c4000, 8'h00, 6'b001101);
      cfg(1, 8'h38, 8'hf8);
      cfg(0, 8'h38, 8'hf8);
      bus(3'b000, 32'h000ec000, 8'h00, 6'b011101);
      ign <= 3'b100;
      bus(3'b000, 32'h000ec000, 8'h00, 6'b001101);
      bus(3'b000, 32'h07ff0000, 8'h00, 6'b000101);
      bus(3'b000, 32'h07f80000, 8'h00, 6'b001101);
      cfg(1, 8'h3a, 8'h08);
      bus(3'b000, 32'hfff80000, 8'h00, 6'b000101);
      dramN <= 1'b0;
      bus(3'b000, 32'h07ff0000, 8'h00, 6'b001101);
      dramN <= 1'b1;
      bus(3'b100, 32'h00000060, 8'h00, 6'b001001);
      bus(3'b100, 32'h00000464, 8'h00, 6'b001001);
      cfg(1, 8'h3a, 8'h04);
      bus(3'b100, 32'h00000464, 8'h00, 6'b001101);
      bus(3'b110, 32'h00000064, 8'hfe, 6'b001011);
      cfg(1, 8'h3a, 8'hc4);
      bus(3'b110, 32'h00000064, 8'hfe, 6'b001101);
      bus(3'b001, 32'h000a0000, 8'h00, 6'b001100);
      cfg(1, 8'h3a, 8'he4);
      bus(3'b001, 32'h000a0000, 8'h00, 6'b001101);
      cfg(1, 8'h3a, 8'h17);
      cfg(0, 8'h3a, 8'h17);
      check("levels", {4'h0, fast, io16, modEn, brEn}, 8'h0f);
      cfg(1, 8'h3a, 8'h00);
      check("levels", {4'h0, fast, io16, modEn, brEn}, 8'h00);
      // A second reset in mid-run must bring back the reset values.
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      cfg(0, 8'h38, 8'hf0);
      cfg(0, 8'h39, 8'h00);
      end_of_test();
   end
endmodule : shadow_cache_region_decode_tb
`default_nettype wire
